// ### smi_regs.vh
// Constants for the serial management interface block.
// Assumes a 40 MHz core clock and inclusion by its bare name.
`ifndef SMI_REGS_VH
`define SMI_REGS_VH

// ==========================================================
// Host serial link ports (three-bit serial addresses)
`define SMI_PORT_INDEX 3'h0
`define SMI_PORT_DATA 3'h2
`define SMI_PORT_FRAME 3'h3
`define SMI_PORT_CTRL 3'h7
`define SMI_IDX_INC 15
`define SMI_IDX_PAIR 14
`define SMI_CMD_READ 1'b1

// ==========================================================
// Bit counts, as last index of each field
`define SMI_ID_LAST 5'h02
`define SMI_ADDR_LAST 5'h02
`define SMI_WIDE_LAST 5'h0F
`define SMI_NARROW_LAST 5'h07
`define SMI_RD_LAST 5'h0F
`define SMI_END_LAST 5'h01
`define SMI_DEB_LAST 2'h2

// ==========================================================
// Boot loader over I2C
`define SMI_CLK_KHZ 40000
`define SMI_I2C_KBPS 50
`define SMI_EE_ADDR 7'h50
`define SMI_EE_WORD 8'h00
`define SMI_BOOT_BASE 12'h000
`define SMI_BOOT_LAST 12'h00F
`define SMI_ACK_BIT 4'h8

`endif

// ### smi_serial_mgmt.v
// Host management interface: serial slave, frame ports, I2C boot loader.
// Assumes a switch core on CLOCK that owns config registers and frames.
//
// What this block does
// - Unmanaged mode: no frames accepted from or delivered to host.
// - Host frame writes on port 3 pass to core for forwarding.
// - Frame interrupt raised while a received frame waits for host.
// - Received frame info and bytes are read in order via port 3.
// - Control frames, up to 40 bytes, pass through port 7.
// - Host control frames for memory and address ops reach the core.
// - Core control frames for the host are readable on port 7.
// - At boot the block reads configuration from an EEPROM as master.
// - I2C bytes of 8 bits at 50 kbps, master makes all clocks.
// - Start is SDA fall with SCL high; stop is SDA rise.
// - SDA changes only while SCL low; both lines high when idle.
// - First byte is seven-bit slave address plus direction bit.
// - Transmitter releases SDA in ack clock; receiver drives it low, except after the last byte read.
// - Missing slave acknowledge ends the transfer with a stop.
// - I2C bytes go most significant bit first.
// - Device is serial slave, no ack bits, shift clock debounce optional.
// - Three-bit strap identifier must match the command identifier.
// - Command is start, address, read/write bit, then data.
// - Start is high at rise, low at fall; abort the reverse.
// - Abort cancels writes anywhere, reads only before read bit.
// - Index port 0 holds config address; data port 2 moves data.
// - Index MSB auto-increments; bit 14 makes one write fill two regs.
module smi_serial_mgmt (
  input wire CLOCK,
  input wire NRST,
  input wire STROBE_N,
  input wire SERIAL_IN,
  output reg SERIAL_OUT,
  output reg SERIAL_OE,
  input wire [2:0] DEVICE_ID,
  input wire DEBOUNCE_EN,
  input wire MANAGED,
  output reg [11:0] CFG_ADDR,
  output reg [7:0] CFG_WDATA,
  output reg CFG_WE,
  output reg CFG_RE,
  input wire [7:0] CFG_RDATA,
  output reg [7:0] TX_DATA,
  output reg FRAME_TX_WE,
  output reg CTRL_TX_WE,
  input wire [7:0] FRAME_RX_DATA,
  input wire FRAME_RX_VALID,
  output reg FRAME_RX_POP,
  output reg FRAME_IRQ,
  input wire [7:0] CTRL_RX_DATA,
  input wire CTRL_RX_VALID,
  output reg CTRL_RX_POP,
  output reg SCL_OUT,
  output reg SCL_OE,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  output reg BOOT_DONE
);
`include "smi_regs.vh"

  localparam S_IDLE = 3'h0;
  localparam S_ID = 3'h1;
  localparam S_ADDR = 3'h2;
  localparam S_CMD = 3'h3;
  localparam S_WDATA = 3'h4;
  localparam S_WEND = 3'h5;
  localparam S_RDATA = 3'h6;

  localparam I_START = 3'h0;
  localparam I_BIT = 3'h1;
  localparam I_STOP = 3'h2;
  localparam I_DONE = 3'h3;

  localparam integer QUARTER = `SMI_CLK_KHZ / (`SMI_I2C_KBPS * 4);
  localparam [7:0] Q_LAST = QUARTER[7:0] - 8'h01;

  // ========================================================
  // Synchronisers
  reg [1:0] stb_s, din_s, din_d, man_s, deb_s, sda_s;
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      stb_s <= 2'b11;
      din_s <= 2'b11;
      din_d <= 2'b11;
      man_s <= 2'b00;
      deb_s <= 2'b00;
      sda_s <= 2'b11;
    end else begin
      stb_s <= {stb_s[0], STROBE_N};
      din_s <= {din_s[0], SERIAL_IN};
      din_d <= {din_d[0], din_s[1]};
      man_s <= {man_s[0], MANAGED};
      deb_s <= {deb_s[0], DEBOUNCE_EN};
      sda_s <= {sda_s[0], SDA_IN};
    end
  end

  // ========================================================
  // Shift clock debounce and edge detection
  // Filter adds two cycles; off lets the host run faster
  reg stb_f, stb_q;
  reg [1:0] deb_cnt;
  reg [2:0] my_id;
  reg id_taken;
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      stb_f <= 1'b1;
      stb_q <= 1'b1;
      deb_cnt <= 2'h0;
      my_id <= 3'h0;
      id_taken <= 1'b0;
    end else begin
      stb_q <= stb_f;
      if (!id_taken) begin
        my_id <= DEVICE_ID;
        id_taken <= 1'b1;
      end
      if (!deb_s[1]) begin
        stb_f <= stb_s[1];
        deb_cnt <= 2'h0;
      end else if (stb_s[1] == stb_f) begin
        deb_cnt <= 2'h0;
      end else if (deb_cnt == `SMI_DEB_LAST) begin
        stb_f <= stb_s[1];
        deb_cnt <= 2'h0;
      end else begin
        deb_cnt <= deb_cnt + 2'h1;
      end
    end
  end
  wire rise = stb_f & ~stb_q;
  wire fall = ~stb_f & stb_q;
  // Data lags by the filter delay, else a fall sees the next bit
  wire bit_in = deb_s[1] ? din_d[1] : din_s[1];
  wire managed = man_s[1];

  // ========================================================
  // Serial command engine
  reg [2:0] state, port;
  reg [4:0] cnt;
  reg [2:0] id_sh;
  reg [15:0] wsh, rsh, idx;
  reg wide, rise_bit, pair_pend;
  reg [7:0] pair_data;
  reg [11:0] pair_addr;
  reg boot_we;
  reg [11:0] boot_addr;
  reg [7:0] boot_data;
  reg [15:0] next_rdata;
  reg next_pop_f, next_pop_c;

  always @* begin
    next_rdata = 16'h0000;
    next_pop_f = 1'b0;
    next_pop_c = 1'b0;
    case (port)
      `SMI_PORT_INDEX: next_rdata = idx;
      `SMI_PORT_DATA: next_rdata = {8'h00, CFG_RDATA};
      `SMI_PORT_FRAME: begin
        if (managed && FRAME_RX_VALID) begin
          next_rdata = {8'h00, FRAME_RX_DATA};
          next_pop_f = 1'b1;
        end
      end
      `SMI_PORT_CTRL: begin
        if (managed && CTRL_RX_VALID) begin
          next_rdata = {8'h00, CTRL_RX_DATA};
          next_pop_c = 1'b1;
        end
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= S_IDLE;
      port <= 3'h0;
      cnt <= 5'h00;
      id_sh <= 3'h0;
      wsh <= 16'h0000;
      rsh <= 16'h0000;
      idx <= 16'h0000;
      wide <= 1'b0;
      rise_bit <= 1'b1;
      pair_pend <= 1'b0;
      pair_data <= 8'h00;
      pair_addr <= 12'h000;
      SERIAL_OUT <= 1'b1;
      SERIAL_OE <= 1'b0;
      CFG_ADDR <= 12'h000;
      CFG_WDATA <= 8'h00;
      CFG_WE <= 1'b0;
      CFG_RE <= 1'b0;
      TX_DATA <= 8'h00;
      FRAME_TX_WE <= 1'b0;
      CTRL_TX_WE <= 1'b0;
      FRAME_RX_POP <= 1'b0;
      CTRL_RX_POP <= 1'b0;
      FRAME_IRQ <= 1'b0;
    end else begin
      CFG_WE <= 1'b0;
      CFG_RE <= 1'b0;
      FRAME_TX_WE <= 1'b0;
      CTRL_TX_WE <= 1'b0;
      FRAME_RX_POP <= 1'b0;
      CTRL_RX_POP <= 1'b0;
      FRAME_IRQ <= managed & FRAME_RX_VALID;
      SERIAL_OE <= (state == S_RDATA);
      if (boot_we) begin
        CFG_ADDR <= boot_addr;
        CFG_WDATA <= boot_data;
        CFG_WE <= 1'b1;
      end else if (pair_pend) begin
        CFG_ADDR <= pair_addr;
        CFG_WDATA <= pair_data;
        CFG_WE <= 1'b1;
        pair_pend <= 1'b0;
      end else begin
        CFG_ADDR <= idx[11:0];
      end
      if (rise) begin
        rise_bit <= bit_in;
      end
      if (fall && rise_bit && !bit_in) begin
        state <= S_ID;
        cnt <= 5'h00;
        SERIAL_OUT <= 1'b1;
      end else if (fall && !rise_bit && bit_in && state != S_RDATA) begin
        state <= S_IDLE;
      end else if (rise && BOOT_DONE) begin
        case (state)
          S_ID: begin
            id_sh <= {bit_in, id_sh[2:1]};
            cnt <= cnt + 5'h01;
            if (cnt == `SMI_ID_LAST) begin
              cnt <= 5'h00;
              if ({bit_in, id_sh[2:1]} == my_id) begin
                state <= S_ADDR;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ADDR: begin
            port <= {bit_in, port[2:1]};
            cnt <= cnt + 5'h01;
            if (cnt == `SMI_ADDR_LAST) begin
              state <= S_CMD;
            end
          end
          S_CMD: begin
            cnt <= 5'h00;
            if (bit_in == `SMI_CMD_READ) begin
              state <= S_RDATA;
              SERIAL_OUT <= next_rdata[0];
              rsh <= {1'b0, next_rdata[15:1]};
              FRAME_RX_POP <= next_pop_f;
              CTRL_RX_POP <= next_pop_c;
              if (port == `SMI_PORT_DATA) begin
                CFG_RE <= 1'b1;
                if (idx[`SMI_IDX_INC]) begin
                  idx[11:0] <= idx[11:0] + 12'h001;
                end
              end
            end else begin
              state <= S_WDATA;
              wide <= (port == `SMI_PORT_INDEX) ||
                      (port == `SMI_PORT_DATA && idx[`SMI_IDX_PAIR]);
            end
          end
          S_WDATA: begin
            wsh <= {bit_in, wsh[15:1]};
            cnt <= cnt + 5'h01;
            if ((wide && cnt == `SMI_WIDE_LAST) ||
                (!wide && cnt == `SMI_NARROW_LAST)) begin
              state <= S_WEND;
              cnt <= 5'h00;
            end
          end
          S_WEND: begin
            // Only high pulses count towards completion
            if (bit_in && cnt != `SMI_END_LAST) begin
              cnt <= `SMI_END_LAST;
            end else if (bit_in) begin
              state <= S_IDLE;
              case (port)
                `SMI_PORT_INDEX: idx <= wsh;
                `SMI_PORT_DATA: begin
                  CFG_ADDR <= idx[11:0];
                  CFG_WDATA <= wide ? wsh[7:0] : wsh[15:8];
                  CFG_WE <= 1'b1;
                  if (wide) begin
                    pair_pend <= 1'b1;
                    pair_data <= wsh[15:8];
                    pair_addr <= idx[11:0] + 12'h001;
                  end
                  if (idx[`SMI_IDX_INC]) begin
                    idx[11:0] <= idx[11:0] + (wide ? 12'h002 : 12'h001);
                  end
                end
                `SMI_PORT_FRAME: begin
                  TX_DATA <= wsh[15:8];
                  FRAME_TX_WE <= managed;
                end
                `SMI_PORT_CTRL: begin
                  TX_DATA <= wsh[15:8];
                  CTRL_TX_WE <= managed;
                end
                default: idx <= idx;
              endcase
            end
          end
          S_RDATA: begin
            // Host samples each bit at the shift clock rising edge
            if (cnt == `SMI_RD_LAST) begin
              state <= S_IDLE;
              SERIAL_OUT <= 1'b1;
            end else begin
              SERIAL_OUT <= rsh[0];
              rsh <= {1'b0, rsh[15:1]};
              cnt <= cnt + 5'h01;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ========================================================
  // I2C boot loader: address write, word address, restart, read
  // No clock stretching support; the EEPROM is assumed fast
  reg [2:0] ist;
  reg [1:0] q, kind;
  reg [7:0] qcnt, tx, rx;
  reg [3:0] bitn;
  reg nack;
  wire tick = (qcnt == Q_LAST);
  wire last = (boot_addr == `SMI_BOOT_LAST);

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ist <= I_START;
      q <= 2'h0;
      kind <= 2'h0;
      qcnt <= 8'h00;
      tx <= {`SMI_EE_ADDR, 1'b0};
      rx <= 8'h00;
      bitn <= 4'h0;
      nack <= 1'b0;
      boot_we <= 1'b0;
      boot_addr <= `SMI_BOOT_BASE;
      boot_data <= 8'h00;
      SCL_OUT <= 1'b0;
      SCL_OE <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      BOOT_DONE <= 1'b0;
    end else begin
      boot_we <= 1'b0;
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
      if (tick && ist != I_DONE) begin
        q <= q + 2'h1;
        case (ist)
          I_START: begin
            // Line levels per quarter: release, SCL up, SDA down, SCL down
            SDA_OE <= (q == 2'h2) || (q == 2'h3);
            SCL_OE <= (q == 2'h0) || (q == 2'h3);
            if (q == 2'h3) begin
              ist <= I_BIT;
              bitn <= 4'h0;
            end
          end
          I_BIT: begin
            SCL_OE <= (q == 2'h3) || (q == 2'h0);
            if (q == 2'h0) begin
              if (bitn == `SMI_ACK_BIT) begin
                SDA_OE <= (kind == 2'h3) && !last;
              end else begin
                SDA_OE <= (kind != 2'h3) && !tx[7];
              end
            end
            if (q == 2'h2) begin
              if (bitn == `SMI_ACK_BIT) begin
                nack <= sda_s[1];
              end else begin
                rx <= {rx[6:0], sda_s[1]};
                tx <= {tx[6:0], 1'b0};
              end
            end
            if (q == 2'h3) begin
              bitn <= bitn + 4'h1;
              if (bitn == `SMI_ACK_BIT) begin
                bitn <= 4'h0;
                case (kind)
                  2'h0: begin
                    kind <= 2'h1;
                    tx <= `SMI_EE_WORD;
                    if (nack) ist <= I_STOP;
                  end
                  2'h1: begin
                    kind <= 2'h2;
                    tx <= {`SMI_EE_ADDR, 1'b1};
                    ist <= nack ? I_STOP : I_START;
                  end
                  2'h2: begin
                    kind <= 2'h3;
                    if (nack) ist <= I_STOP;
                  end
                  default: begin
                    boot_we <= 1'b1;
                    boot_data <= rx;
                    boot_addr <= boot_addr + 12'h001;
                    if (last) ist <= I_STOP;
                  end
                endcase
              end
            end
          end
          I_STOP: begin
            SCL_OE <= (q == 2'h0);
            SDA_OE <= (q == 2'h0) || (q == 2'h1);
            if (q == 2'h3) begin
              ist <= I_DONE;
              BOOT_DONE <= 1'b1;
            end
          end
          default: ist <= I_DONE;
        endcase
      end
    end
  end

endmodule // smi_serial_mgmt

// ### smi_serial_mgmt_checker.sv
// Port checker for the serial management block.
// Assumes a bind to smi_serial_mgmt and the single CLOCK domain.
module smi_serial_mgmt_checker (
  input wire CLOCK,
  input wire NRST,
  input wire MANAGED,
  input wire FRAME_RX_VALID,
  input wire FRAME_IRQ,
  input wire FRAME_RX_POP,
  input wire CTRL_RX_POP,
  input wire FRAME_TX_WE,
  input wire CTRL_TX_WE,
  input wire CFG_RE,
  input wire SERIAL_OE,
  input wire SCL_OUT,
  input wire SCL_OE,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire BOOT_DONE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // ====
  // Frame path and boot gating; five cycles cover the mode synchroniser
  a_irq_gated_off: assert property ((!MANAGED) [*5] |-> !FRAME_IRQ)
    else $error("frame interrupt in unmanaged mode");
  a_irq_raised: assert property (
    (MANAGED && FRAME_RX_VALID) [*5] |-> FRAME_IRQ)
    else $error("no frame interrupt with frame waiting");
  a_frames_blocked: assert property (
    (!MANAGED) [*5] |->
      !(FRAME_RX_POP || CTRL_RX_POP || FRAME_TX_WE || CTRL_TX_WE))
    else $error("frame traffic in unmanaged mode");
  a_cmd_after_boot: assert property (
    !BOOT_DONE |-> !CFG_RE && !SERIAL_OE)
    else $error("serial command served before boot end");
  // ====
  // Boot bus, open drain
  a_open_drain: assert property (!SCL_OUT && !SDA_OUT)
    else $error("bus line driven high");
  a_start_clocks: assert property (
    $rose(SDA_OE) && !SCL_OE |-> ##[1:420] SCL_OE)
    else $error("no clock after start");
  a_stop_frees: assert property (
    $fell(SDA_OE) && !SCL_OE && !$past(SCL_OE) |-> ##[0:420] BOOT_DONE)
    else $error("boot not ended after stop");
  a_idle_high: assert property (BOOT_DONE |-> !SCL_OE && !SDA_OE)
    else $error("bus not idle after boot");
endmodule // smi_serial_mgmt_checker

// ### smi_host_model.sv
// Host model: master on the serial management link.
// Assumes CLK is the 40 MHz core clock; strobe period is 8 cycles.
module smi_host_model (
  input wire CLK,
  input wire SERIAL_OUT,
  output logic STROBE_N,
  output logic SERIAL_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    STROBE_N = 1'b1;
    SERIAL_IN = 1'b1;
  end
  // ====
  // One strobe period; data moves only while the strobe is low
  task automatic pulse(input logic b, output logic s);
    @(negedge CLK);
    STROBE_N = 1'b0;
    repeat (2) @(negedge CLK);
    SERIAL_IN = b;
    repeat (2) @(negedge CLK);
    s = SERIAL_OUT;
    STROBE_N = 1'b1;
    repeat (3) @(negedge CLK);
  endtask
  // Start or abort: data flips while the strobe is high
  task automatic mark(input logic a, input logic b);
    logic s;
    pulse(a, s);
    SERIAL_IN = b;
  endtask
  task automatic cmd(input logic [2:0] id, input logic [2:0] port,
      input logic rd, input logic [15:0] wd, input int nb, input int cut,
      output logic [15:0] rv);
    logic s;
    int i;
    rv = 16'h0000;
    mark(1'b1, 1'b0);
    for (i = 0; i < 3; i++) pulse(id[i], s);
    for (i = 0; i < 3; i++) pulse(port[i], s);
    pulse(rd, s);
    for (i = 0; i < 16 && rd; i++) begin
      pulse(1'b1, s);
      rv[i] = s;
    end
    for (i = 0; i < nb && !rd; i++) begin
      if (i == cut) begin
        mark(1'b0, 1'b1);
        pulse(1'b1, s);
        return;
      end
      pulse(wd[i], s);
    end
    if (!rd) repeat (2) pulse(1'b1, s);
    repeat (8) @(negedge CLK);
  endtask
endmodule // smi_host_model

// ### test_smi_serial_mgmt.sv
// Testbench for the serial management block.
// Assumes no EEPROM on the boot bus (pull-up only) and a core stub here.
`include "smi_regs.vh"
module test_smi_serial_mgmt;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ID = 3'h5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic deb_en = 1'b0;
  logic managed = 1'b0;
  logic frx_valid = 1'b0;
  logic crx_valid = 1'b0;
  logic [7:0] frx_data = 8'h00;
  logic [7:0] crx_data = 8'h00;
  logic [7:0] i2c_byte = 8'h00;
  logic strobe_n, serial_in, serial_out, serial_oe, cfg_we, cfg_re;
  logic frame_tx_we, ctrl_tx_we, frame_rx_pop, frame_irq, ctrl_rx_pop;
  logic scl_out, scl_oe, sda_out, sda_oe, boot_done;
  logic [7:0] cfg_wdata, tx_data;
  logic [11:0] cfg_addr;
  logic [15:0] rv;
  logic [7:0] mem [0:4095];
  logic [7:0] fq[$];
  logic [7:0] cq[$];
  logic [19:0] wlog[$];
  logic [8:0] tlog[$];
  time t_scl = 0;
  time scl_per = 0;
  int i2c_bits = 0;
  int scl_rel = 0;
  int oe_cnt = 0;
  int bad_count = 0;
  int checks_done = 0;
  wire [7:0] cfg_rdata = mem[cfg_addr];
  wire sda_in = ~sda_oe;
  smi_serial_mgmt DUT (
    .CLOCK(clk), .NRST(nrst), .STROBE_N(strobe_n), .SERIAL_IN(serial_in),
    .SERIAL_OUT(serial_out), .SERIAL_OE(serial_oe), .DEVICE_ID(ID),
    .DEBOUNCE_EN(deb_en), .MANAGED(managed), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_WE(cfg_we), .CFG_RE(cfg_re),
    .CFG_RDATA(cfg_rdata), .TX_DATA(tx_data), .FRAME_TX_WE(frame_tx_we),
    .CTRL_TX_WE(ctrl_tx_we), .FRAME_RX_DATA(frx_data),
    .FRAME_RX_VALID(frx_valid), .FRAME_RX_POP(frame_rx_pop),
    .FRAME_IRQ(frame_irq), .CTRL_RX_DATA(crx_data),
    .CTRL_RX_VALID(crx_valid), .CTRL_RX_POP(ctrl_rx_pop),
    .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .BOOT_DONE(boot_done));
  smi_host_model host (.CLK(clk), .SERIAL_OUT(serial_out),
    .STROBE_N(strobe_n), .SERIAL_IN(serial_in));
  // ====
  // Core stub: config memory, tx log, rx queues
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (cfg_we) begin
      mem[cfg_addr] <= cfg_wdata;
      wlog.push_back({cfg_addr, cfg_wdata});
    end
    if (serial_oe) oe_cnt++;
    if (frame_tx_we) tlog.push_back({1'b0, tx_data});
    if (ctrl_tx_we) tlog.push_back({1'b1, tx_data});
    if (frame_rx_pop) void'(fq.pop_front());
    if (ctrl_rx_pop) void'(cq.pop_front());
  end
  // Empty queues show junk so a read that ignores valid is caught
  always @(negedge clk) begin
    frx_valid = fq.size() > 0;
    frx_data = frx_valid ? fq[0] : 8'hEE;
    crx_valid = cq.size() > 0;
    crx_data = crx_valid ? cq[0] : 8'hEE;
  end
  always @(negedge scl_oe)
    if (nrst) begin
      // The start's own clock release carries no data bit
      if (scl_rel > 0 && i2c_bits < 8) begin
        if (i2c_bits == 1) scl_per = $time - t_scl;
        t_scl = $time;
        i2c_byte = {i2c_byte[6:0], sda_in};
        i2c_bits++;
      end
      scl_rel++;
    end
  // ====
  // Shared helpers
  task automatic check(input string what, input logic [19:0] exp,
      input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] port, input logic [15:0] d,
      input int nb);
    host.cmd(ID, port, 1'b0, d, nb, 99, rv);
  endtask
  task automatic rd(input logic [2:0] port, input logic [15:0] exp,
      input string what);
    oe_cnt = 0;
    host.cmd(ID, port, `SMI_CMD_READ, 16'h0000, 0, 99, rv);
    check(what, 20'(exp), 20'(rv));
    check("read drive", 20'h00001, 20'(oe_cnt > 0 && serial_oe === 1'b0));
  endtask
  task automatic final_report;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_boot;
    int n;
    for (n = 0; n < 30000 && boot_done !== 1'b1; n++) @(negedge clk);
    check("boot done", 20'h00001, 20'(boot_done));
    if (boot_done !== 1'b1) final_report();
    check("addr byte", 20'({`SMI_EE_ADDR, 1'b0}), 20'(i2c_byte));
    check("scl period", 20'(1000000 / `SMI_I2C_KBPS), scl_per[19:0]);
    check("boot writes", 20'h00000, 20'(wlog.size()));
    $display("t_boot done");
  endtask
  task automatic t_cfg(input logic deb);
    deb_en = deb;
    repeat (8) @(negedge clk);
    wlog.delete();
    wr(`SMI_PORT_INDEX, 16'h0012, 16);
    wr(`SMI_PORT_DATA, 16'h005A, 8);
    check("cfg write", 20'h0125A, wlog[0]);
    rd(`SMI_PORT_DATA, 16'h005A, "cfg read");
    rd(`SMI_PORT_INDEX, 16'h0012, "index read");
    $display("t_cfg done");
  endtask
  task automatic t_wide;
    wr(`SMI_PORT_INDEX, 16'hC020, 16);
    wlog.delete();
    wr(`SMI_PORT_DATA, 16'hBEEF, 16);
    check("wide low", 20'h020EF, wlog[0]);
    check("wide high", 20'h021BE, wlog[1]);
    rd(`SMI_PORT_INDEX, 16'hC022, "index step 2");
    wr(`SMI_PORT_INDEX, 16'h8030, 16);
    rd(`SMI_PORT_DATA, 16'h0011, "inc read 0");
    rd(`SMI_PORT_DATA, 16'h0022, "inc read 1");
    rd(`SMI_PORT_INDEX, 16'h8032, "index step 1");
    $display("t_wide done");
  endtask
  task automatic t_refuse;
    wlog.delete();
    host.cmd(ID ^ 3'h1, `SMI_PORT_DATA, 1'b0, 16'h00AA, 8, 99, rv);
    host.cmd(ID, `SMI_PORT_DATA, 1'b0, 16'h0055, 8, 4, rv);
    check("refused writes", 20'h00000, 20'(wlog.size()));
    wr(`SMI_PORT_DATA, 16'h0033, 8);
    check("write after abort", 20'h03233, wlog[0]);
    $display("t_refuse done");
  endtask
  task automatic t_frames;
    managed = 1'b1;
    fq = '{8'h40, 8'h03};
    repeat (8) @(negedge clk);
    check("irq set", 20'h00001, 20'(frame_irq));
    rd(`SMI_PORT_FRAME, 16'h0040, "frame head");
    rd(`SMI_PORT_FRAME, 16'h0003, "frame next");
    check("irq clear", 20'h00000, 20'(frame_irq));
    cq.push_back(8'h77);
    rd(`SMI_PORT_CTRL, 16'h0077, "ctrl rx");
    check("ctrl pop", 20'h00000, 20'(cq.size()));
    tlog.delete();
    wr(`SMI_PORT_FRAME, 16'h00A5, 8);
    wr(`SMI_PORT_CTRL, 16'h003C, 8);
    check("frame tx", 20'h000A5, 20'(tlog[0]));
    check("ctrl tx", 20'h0013C, 20'(tlog[1]));
    managed = 1'b0;
    fq.push_back(8'h99);
    repeat (8) @(negedge clk);
    check("irq off", 20'h00000, 20'(frame_irq));
    rd(`SMI_PORT_FRAME, 16'h0000, "blocked rx");
    wr(`SMI_PORT_FRAME, 16'h0066, 8);
    check("blocked pop", 20'h00001, 20'(fq.size()));
    check("blocked tx", 20'h00002, 20'(tlog.size()));
    $display("t_frames done");
  endtask
  initial begin
    mem[12'h030] = 8'h11;
    mem[12'h031] = 8'h22;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_boot();
    t_cfg(1'b1);
    t_cfg(1'b0);
    t_wide();
    t_refuse();
    t_frames();
    final_report();
  end
endmodule // test_smi_serial_mgmt
bind smi_serial_mgmt smi_serial_mgmt_checker chk (
  .CLOCK(CLOCK), .NRST(NRST), .MANAGED(MANAGED),
  .FRAME_RX_VALID(FRAME_RX_VALID), .FRAME_IRQ(FRAME_IRQ),
  .FRAME_RX_POP(FRAME_RX_POP), .CTRL_RX_POP(CTRL_RX_POP),
  .FRAME_TX_WE(FRAME_TX_WE), .CTRL_TX_WE(CTRL_TX_WE), .CFG_RE(CFG_RE),
  .SERIAL_OE(SERIAL_OE), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .BOOT_DONE(BOOT_DONE));
